// ### common/pfsel_pkg.sv
// Package with the addresses, field positions and carrier types of the pin function selector.
package pfsel_pkg;

  // ************************************************************
  // Register map
  // ************************************************************

  // Byte addresses of the two function select registers.
  localparam logic [31:0] PORT0_ADDR = 32'hffff0d00;
  localparam logic [31:0] PORT1_ADDR = 32'hffff0d04;

  // Reset values of the two function select registers.
  localparam logic [31:0] PORT0_RESET = 32'h11100000;
  localparam logic [31:0] PORT1_RESET = 32'h10000000;

  // Value returned for a read of an address that holds no register.
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // ************************************************************
  // Field positions
  // ************************************************************

  // The SPI select bits sit four bits apart, starting at bit 0.
  localparam int SPI_SEL_STRIDE = 4;
  localparam int P0_DIVIDED_CLOCK_OUTPUT_BIT = 16;
  localparam int P0_HVA_BIT = 20;
  localparam int P0_HVB_BIT = 24;
  localparam int P1_RXD_BIT = 0;
  localparam int P1_TXD_BIT = 4;

  // ************************************************************
  // Pins and lines
  // ************************************************************

  // Seven external pins: port 0 is pins 0 to 4, port 1 is pins 5 and 6.
  localparam int NUM_PINS = 7;
  localparam int NUM_SPI = 4;
  localparam int PIN_DIVIDED_CLOCK_OUTPUT = 4;
  localparam int PIN_RXD = 5;
  localparam int PIN_TXD = 6;

  // SPI lines in pin order: slave select, clock, MISO, MOSI.
  localparam int SPI_SS = 0;
  localparam int SPI_SCLK = 1;
  localparam int SPI_MISO = 2;
  localparam int SPI_MOSI = 3;

  // Idle levels handed to a peripheral whose pin is not routed to it.
  localparam logic [3:0] SPI_IDLE_IN = 4'h1;
  localparam logic UART_RX_IDLE = 1'b1;

  // Pins carry pull-ups, so the synchronisers start at all ones.
  localparam logic [6:0] PIN_SYNC_RESET = 7'h7f;

  // Drive requests from the SPI block, one bit per line.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] drive;
  } pfsel_spi_out_type;

  // Registered pad controls; oe_n low means the pin is driven.
  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe_n;
  } pfsel_pad_type;

endpackage

// ### hw/pfsel_sync.sv
// Two flip-flop synchroniser for pin inputs.
module pfsel_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage; only the second stage reads it, so metastability has a cycle to settle.
  logic [WIDTH-1:0] stage1_reg;

  // ************************************************************
  // Synchroniser chain
  // ************************************************************

  // Both stages reset to the idle level of the pins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

// ### hw/pfsel_port_mux.sv
// Function select registers and pin multiplexer for the two small ports.
//
// The implementer's own choice: the strobed register port.

// Functional notes
// [R1] Port0 bit16 selects clock output on pin4.
// [R2] Port0 bit12 selects SPI MOSI on pin3.
// [R3] Port0 bit8 selects SPI MISO on pin2.
// [R4] Port0 bit4 selects SPI clock on pin1.
// [R5] Port0 bit0 selects SPI slave select on pin0.
// [R6] Software sets bit24 before high-voltage link use.
// [R7] Software sets bit20 before high-voltage link use.
// [R8] Software always writes one to bit28.
// [R9] Software writes zero to other reserved bits.
// [R10] Port1 bit4 selects UART transmit on pin6.
// [R11] Port1 bit0 selects UART receive from pin5.
// [R12] Port1 register is 32-bit read/write.
// [R13] Selected peripheral pins ignore plain port driver.
module pfsel_port_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe_n,
  input wire logic [6:0] gpio_out,
  input wire logic [6:0] gpio_drive,
  output logic [6:0] gpio_in,
  input wire pfsel_pkg::pfsel_spi_out_type spi_out,
  output logic [3:0] spi_in,
  input wire logic divided_clock_output,
  input wire logic uart_txd,
  output logic uart_rxd,
  output logic internal_hv_line_a,
  output logic internal_hv_line_b
);

  // ************************************************************
  // Declarations
  // ************************************************************

  // Function select register of port 0.
  logic [31:0] port0_function_select_reg;
  // Function select register of port 1.
  logic [31:0] port1_function_select_reg;
  // Pin levels after the synchroniser.
  logic [6:0] pin_sync;
  // Next pad controls, worked out from the selects.
  pfsel_pkg::pfsel_pad_type pad_next;
  // Registered pad controls that reach the pins.
  pfsel_pkg::pfsel_pad_type pad_reg;
  // Next inputs for the SPI block.
  logic [3:0] spi_in_next;

  // Tests one select bit of a register.
  function automatic logic sel_bit(input logic [31:0] value, input int pos);
    sel_bit = value[pos];
  endfunction

  // ************************************************************
  // Register port
  // ************************************************************

  // Writes land whole; reserved bits are stored as written so software reads back what it wrote.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port0_function_select_reg <= pfsel_pkg::PORT0_RESET;
    end else if (wr && addr == pfsel_pkg::PORT0_ADDR) begin
      port0_function_select_reg <= wdata;
    end
  end

  // Port 1 is a full 32-bit read/write register. [R12]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port1_function_select_reg <= pfsel_pkg::PORT1_RESET;
    end else if (wr && addr == pfsel_pkg::PORT1_ADDR) begin
      port1_function_select_reg <= wdata;
    end
  end

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= pfsel_pkg::UNMAPPED_DATA;
    end else if (rd && addr == pfsel_pkg::PORT0_ADDR) begin
      rdata <= port0_function_select_reg;
    end else if (rd && addr == pfsel_pkg::PORT1_ADDR) begin
      rdata <= port1_function_select_reg; // [R12]
    end else begin
      rdata <= pfsel_pkg::UNMAPPED_DATA;
    end
  end

  // ************************************************************
  // Pin input synchroniser
  // ************************************************************

  // Pins are asynchronous, so every reader sees them only through this chain.
  pfsel_sync #(
    .WIDTH(pfsel_pkg::NUM_PINS),
    .RESET_VAL(pfsel_pkg::PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ************************************************************
  // Output multiplexer
  // ************************************************************

  // Each pin defaults to the plain port driver; a set select hands it to its peripheral.
  always_comb begin
    pad_next.out = gpio_out;
    pad_next.oe_n = ~gpio_drive;
    // SPI lines sit on pins 0 to 3 with selects every fourth bit.
    for (int i = 0; i < pfsel_pkg::NUM_SPI; i++) begin
      if (sel_bit(port0_function_select_reg, i * pfsel_pkg::SPI_SEL_STRIDE)) begin
        pad_next.out[i] = spi_out.out[i]; // [R2] [R3] [R4] [R5] [R13]
        pad_next.oe_n[i] = ~spi_out.drive[i]; // [R2] [R3] [R4] [R5] [R13]
      end
    end
    // The divided clock always drives its pin when selected.
    if (sel_bit(port0_function_select_reg, pfsel_pkg::P0_DIVIDED_CLOCK_OUTPUT_BIT)) begin
      pad_next.out[pfsel_pkg::PIN_DIVIDED_CLOCK_OUTPUT] = divided_clock_output; // [R1]
      pad_next.oe_n[pfsel_pkg::PIN_DIVIDED_CLOCK_OUTPUT] = 1'b0; // [R1] [R13]
    end
    // The receive pin is input only, so the plain driver is released.
    if (sel_bit(port1_function_select_reg, pfsel_pkg::P1_RXD_BIT)) begin
      pad_next.out[pfsel_pkg::PIN_RXD] = 1'b0;
      pad_next.oe_n[pfsel_pkg::PIN_RXD] = 1'b1; // [R11] [R13]
    end
    // The transmit pin is driven by the UART alone.
    if (sel_bit(port1_function_select_reg, pfsel_pkg::P1_TXD_BIT)) begin
      pad_next.out[pfsel_pkg::PIN_TXD] = uart_txd; // [R10]
      pad_next.oe_n[pfsel_pkg::PIN_TXD] = 1'b0; // [R10] [R13]
    end
  end

  // Pad controls are registered so the pins never see combinational glitches.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_reg.out <= '0;
      pad_reg.oe_n <= '1;
    end else begin
      pad_reg <= pad_next;
    end
  end

  assign pin_out = pad_reg.out;
  assign pin_oe_n = pad_reg.oe_n;

  // ************************************************************
  // Input routing
  // ************************************************************

  // A peripheral whose pin is not routed sees its idle level, so a stray pin cannot wake it.
  always_comb begin
    spi_in_next = pfsel_pkg::SPI_IDLE_IN;
    for (int i = 0; i < pfsel_pkg::NUM_SPI; i++) begin
      if (sel_bit(port0_function_select_reg, i * pfsel_pkg::SPI_SEL_STRIDE)) begin
        spi_in_next[i] = pin_sync[i]; // [R2] [R3] [R4] [R5]
      end
    end
  end

  // Registered inputs for SPI and the plain port readback.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_in <= pfsel_pkg::SPI_IDLE_IN;
      gpio_in <= pfsel_pkg::PIN_SYNC_RESET;
    end else begin
      spi_in <= spi_in_next;
      gpio_in <= pin_sync;
    end
  end

  // UART receive follows pin 5 only while it is selected.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uart_rxd <= pfsel_pkg::UART_RX_IDLE;
    end else if (sel_bit(port1_function_select_reg, pfsel_pkg::P1_RXD_BIT)) begin
      uart_rxd <= pin_sync[pfsel_pkg::PIN_RXD]; // [R11]
    end else begin
      uart_rxd <= pfsel_pkg::UART_RX_IDLE;
    end
  end

  // ************************************************************
  // Internal high-voltage link enables
  // ************************************************************

  // Software must set both enables before touching the link registers. [R6] [R7]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_hv_line_a <= 1'b0;
      internal_hv_line_b <= 1'b0;
    end else begin
      internal_hv_line_a <= port0_function_select_reg[pfsel_pkg::P0_HVA_BIT];
      internal_hv_line_b <= port0_function_select_reg[pfsel_pkg::P0_HVB_BIT];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A write to port 1 followed at once by a read of port 1.
  sequence s_p1_write_read;
    wr && addr == pfsel_pkg::PORT1_ADDR ##1 rd && addr == pfsel_pkg::PORT1_ADDR;
  endsequence

  // A select bit held long enough for a pin level to pass the input path.
  sequence s_rxd_held;
    port1_function_select_reg[pfsel_pkg::P1_RXD_BIT] [*4];
  endsequence

  a_p1_reg_readback: assert property (s_p1_write_read |=> rdata == $past(wdata, 2)) // [R12]
    else $error("Port 1 register did not read back the written word.");

  a_divided_clock_output_pin_route: assert property ( // [R1]
    port0_function_select_reg[pfsel_pkg::P0_DIVIDED_CLOCK_OUTPUT_BIT]
    |=> !pin_oe_n[pfsel_pkg::PIN_DIVIDED_CLOCK_OUTPUT]
    && pin_out[pfsel_pkg::PIN_DIVIDED_CLOCK_OUTPUT] == $past(divided_clock_output))
    else $error("Clock output not routed to pin 4.");

  a_mosi_pin_route: assert property ( // [R2]
    port0_function_select_reg[pfsel_pkg::SPI_MOSI * pfsel_pkg::SPI_SEL_STRIDE]
    |=> pin_out[pfsel_pkg::SPI_MOSI] == $past(spi_out.out[pfsel_pkg::SPI_MOSI])
    && pin_oe_n[pfsel_pkg::SPI_MOSI] == !$past(spi_out.drive[pfsel_pkg::SPI_MOSI]))
    else $error("MOSI not routed to pin 3.");

  a_miso_pin_route: assert property ( // [R3]
    port0_function_select_reg[pfsel_pkg::SPI_MISO * pfsel_pkg::SPI_SEL_STRIDE]
    |=> pin_out[pfsel_pkg::SPI_MISO] == $past(spi_out.out[pfsel_pkg::SPI_MISO])
    && pin_oe_n[pfsel_pkg::SPI_MISO] == !$past(spi_out.drive[pfsel_pkg::SPI_MISO]))
    else $error("MISO not routed to pin 2.");

  a_sclk_pin_route: assert property ( // [R4]
    port0_function_select_reg[pfsel_pkg::SPI_SCLK * pfsel_pkg::SPI_SEL_STRIDE]
    |=> pin_out[pfsel_pkg::SPI_SCLK] == $past(spi_out.out[pfsel_pkg::SPI_SCLK])
    && pin_oe_n[pfsel_pkg::SPI_SCLK] == !$past(spi_out.drive[pfsel_pkg::SPI_SCLK]))
    else $error("SPI clock not routed to pin 1.");

  a_ss_input_route: assert property ( // [R5]
    port0_function_select_reg[pfsel_pkg::SPI_SS * pfsel_pkg::SPI_SEL_STRIDE] [*4]
    |-> spi_in[pfsel_pkg::SPI_SS] == $past(pin_in[pfsel_pkg::SPI_SS], 3))
    else $error("Slave select pin not passed to SPI.");

  a_txd_pin_route: assert property ( // [R10]
    port1_function_select_reg[pfsel_pkg::P1_TXD_BIT]
    |=> !pin_oe_n[pfsel_pkg::PIN_TXD] && pin_out[pfsel_pkg::PIN_TXD] == $past(uart_txd))
    else $error("UART transmit not routed to pin 6.");

  a_rxd_input_route: assert property ( // [R11]
    s_rxd_held |-> uart_rxd == $past(pin_in[pfsel_pkg::PIN_RXD], 3))
    else $error("Pin 5 not passed to UART receive.");

  a_gpio_driver_off: assert property ( // [R13]
    port1_function_select_reg[pfsel_pkg::P1_RXD_BIT] |=> pin_oe_n[pfsel_pkg::PIN_RXD])
    else $error("Plain driver still drives the UART receive pin.");

endmodule

// ### bench/pfsel_far_model.sv
// Behavioural model of the pads and of the outside parts wired to them.
module pfsel_far_model (
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe_n,
  input wire logic [6:0] ext_drive,
  input wire logic [6:0] ext_val,
  output logic [6:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Pad resolution
  // ************************************************************

  // The device drive wins, then an outside driver, else the pull-up holds the pin high.
  // Contention is not modelled, so tests must never drive a pin from both sides.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!pin_oe_n[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_drive[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking testbench of the pin function selector.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [6:0] pin_level;
  logic [6:0] pin_out;
  logic [6:0] pin_oe_n;
  logic [6:0] gpio_in;
  logic [6:0] gpio_out = 7'h55;
  logic [6:0] gpio_drive = 7'h7f;
  logic [6:0] ext_drive = 7'h00;
  logic [6:0] ext_val = 7'h00;
  // Upper nibble is the line values, lower nibble the drive requests.
  pfsel_pkg::pfsel_spi_out_type spi_out = 8'ha6;
  logic [3:0] spi_in;
  logic clk_src = 1'b1;
  logic uart_txd = 1'b0;
  logic uart_rxd;
  logic hv_a;
  logic hv_b;
  int n_mismatch = 0;
  int n_compared = 0;

  // The 10 MHz system clock.
  always #50 clk = ~clk;

  pfsel_port_mux dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gpio_out(gpio_out), .gpio_drive(gpio_drive), .gpio_in(gpio_in), .spi_out(spi_out),
    .spi_in(spi_in), .divided_clock_output(clk_src), .uart_txd(uart_txd),
    .uart_rxd(uart_rxd), .internal_hv_line_a(hv_a), .internal_hv_line_b(hv_b));

  pfsel_far_model far_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext_drive),
    .ext_val(ext_val), .pin_level(pin_level));

  // ************************************************************
  // Shared tasks
  // ************************************************************

  // Compares with case equality so an unknown never counts as a match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe; the register loads at the edge on which the task returns.
  task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Write strobe followed at once by a read strobe of the same address, with no gap.
  task automatic write_read(input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  // Lets the pad and synchroniser stages catch up with new inputs.
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************

  // Reset values, an unmapped read, and rdata returning to zero.
  task automatic t_reset();
    read_reg(pfsel_pkg::PORT0_ADDR, rv);
    check(rv, pfsel_pkg::PORT0_RESET, "port0 reset");
    read_reg(pfsel_pkg::PORT1_ADDR, rv);
    check(rv, pfsel_pkg::PORT1_RESET, "port1 reset");
    @(posedge clk);
    #1 check(rdata, 32'h0, "rdata idle");
    read_reg(32'hffff0d08, rv);
    check(rv, pfsel_pkg::UNMAPPED_DATA, "unmapped read");
    check({hv_b, hv_a}, 2'h3, "hv lines after reset");
  endtask

  // Back-to-back write and read of port1, and an ignored unmapped write.
  task automatic t_regs();
    write_read(pfsel_pkg::PORT1_ADDR, 32'h00000011, rv);
    check(rv, 32'h00000011, "port1 readback");
    write_reg(32'hffff0d08, 32'h00000001);
    read_reg(pfsel_pkg::PORT0_ADDR, rv);
    check(rv, pfsel_pkg::PORT0_RESET, "port0 after unmapped write");
    write_reg(pfsel_pkg::PORT1_ADDR, 32'h00000000);
  endtask

  // All pins in plain mode follow the plain port driver.
  task automatic t_gpio();
    write_reg(pfsel_pkg::PORT0_ADDR, 32'h10000000);
    settle();
    check(pin_out, 7'h55, "plain pin values");
    check(pin_oe_n, 7'h00, "plain pin enables");
    check({hv_b, hv_a}, 2'h0, "hv lines cleared");
  endtask

  // Every peripheral selected while the plain driver keeps asking to drive.
  task automatic t_select();
    write_reg(pfsel_pkg::PORT0_ADDR, 32'h11111111);
    write_reg(pfsel_pkg::PORT1_ADDR, 32'h00000011);
    settle();
    check(pin_oe_n, 7'h29, "peripheral enables");
    check(pin_out[2:1], 2'h1, "spi outputs");
    check(pin_out[6], 1'b0, "uart transmit");
    check(pin_out[4], 1'b1, "clock high");
    check({hv_b, hv_a}, 2'h3, "hv lines set");
    @(posedge clk);
    clk_src <= 1'b0;
    ext_drive <= 7'h29;
    settle();
    check(pin_out[4], 1'b0, "clock low");
    check(spi_in, 4'h2, "spi inputs");
    check(uart_rxd, 1'b0, "uart receive");
    check(gpio_in, 7'h02, "pin readback");
  endtask

  // Deselected peripherals see their idle levels again.
  task automatic t_deselect();
    @(posedge clk);
    ext_drive <= 7'h00;
    write_reg(pfsel_pkg::PORT1_ADDR, 32'h00000000);
    write_reg(pfsel_pkg::PORT0_ADDR, 32'h11100000);
    settle();
    check(spi_in, pfsel_pkg::SPI_IDLE_IN, "spi idle");
    check(uart_rxd, 1'b1, "uart idle");
    check(pin_oe_n, 7'h00, "plain again");
  endtask

  // ************************************************************
  // Run control
  // ************************************************************

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence: hold reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_gpio();
    t_select();
    t_deselect();
    final_report();
  end

  // The scenarios need about 50 cycles; 2000 leaves ample margin.
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
